// ===== src/region_attr_pkg.sv
// constants, field layouts and carrier types for the region attribute block
// assumes one processor clock and the control-register port of the core
package region_attr_pkg;

  localparam int unsigned BASE_W        = 25;          // base field, address bits 6..30
  localparam int unsigned BASE_LSB      = 6;
  localparam int unsigned LIMIT_W       = BASE_W + 1;  // limit reaches bit 31
  localparam int unsigned IDX_W         = 5;           // up to 32 regions per kind
  localparam int unsigned NUM_REGIONS   = 32;
  localparam int unsigned ACCESS_PERMISSION_CODE_W        = 3;

  // attribute register field positions
  localparam int unsigned WR_BIT        = 0;
  localparam int unsigned RD_BIT        = 1;
  localparam int unsigned ACCESS_PERMISSION_CODE_LSB      = 2;
  localparam int unsigned CACHE_BIT     = 5;
  localparam int unsigned SIZE_LSB      = 6;

  // base register field positions
  localparam int unsigned DSEL_BIT      = 0;
  localparam int unsigned IDX_LSB       = 1;

  // control-register numbers on the core's port
  localparam logic [4:0]  CTL_BASE_NUM  = 5'h0E;
  localparam logic [4:0]  CTL_ATTR_NUM  = 5'h0F;

  // values after reset
  localparam logic [31:0] ATTR_RESET    = 32'h0000_0000;
  localparam logic [31:0] BASE_RESET    = 32'h0000_0000;

  // permission codes, instruction regions
  localparam logic [2:0]  ACCESS_PERMISSION_CODE_NONE     = 3'h0;
  localparam logic [2:0]  ACCESS_PERMISSION_CODE_I_SUP_X  = 3'h1;
  localparam logic [2:0]  ACCESS_PERMISSION_CODE_I_ALL_X  = 3'h2;
  // permission codes, data regions
  localparam logic [2:0]  ACCESS_PERMISSION_CODE_D_SUP_R  = 3'h1;
  localparam logic [2:0]  ACCESS_PERMISSION_CODE_D_ALL_R  = 3'h2;
  localparam logic [2:0]  ACCESS_PERMISSION_CODE_D_SUP_RW = 3'h4;
  localparam logic [2:0]  ACCESS_PERMISSION_CODE_D_SUP_RW_USR_R = 3'h5;
  localparam logic [2:0]  ACCESS_PERMISSION_CODE_D_ALL_RW = 3'h6;

  typedef enum logic [1:0] {
    ACC_NONE,
    ACC_READ,
    ACC_WRITE
  } acc_kind_t;

  // one stored region entry
  typedef struct packed {
    logic [BASE_W-1:0]  base;
    logic [LIMIT_W-1:0] size;   // mask uses the low BASE_W bits only
    logic               cache;
    logic [ACCESS_PERMISSION_CODE_W-1:0]  access_permission_code;
  } region_entry_t;

  // access check request from the pipeline
  typedef struct packed {
    logic        valid;
    logic        data;        // 1 data access, 0 fetch
    logic        user;        // 1 user mode
    logic        store;       // data write
    logic        io_insn;     // uncached load or store instruction
    logic [31:0] addr;
  } check_req_t;

  // verdict of an access check
  typedef struct packed {
    logic valid;
    logic hit;
    logic allow;
    logic cacheable;
  } check_rsp_t;

endpackage : region_attr_pkg

// ===== src/region_attr_access.sv
// region attribute and base control registers with the region table
// assumes the core presents control-register writes and reads on its
// own clock, one access a cycle; protection enable comes from the config
// register elsewhere.
// Notes on behaviour
// R1: mask width equals base field width
// R2: unused mask bits write zero, read zero
// R3: mask is ones shifted by log2 size/64
// R4: bit 31 unused in the mask variant
// R5: limit is upper address plus one, scaled
// R6: limit one bit wider, reaching bit 31
// R7: mask or limit fixed at generation
// R8: cacheable flag sets data region cacheability
// R9: cacheable flag zero for instruction regions
// R10: cache only with data cache; io uncached
// R11: bit 31 cache bypass kept under protection
// R12: instruction permission codes 0, 1, 2
// R13: data permission codes 0,1,2,4,5,6
// R14: software avoids unlisted permission codes
// R15: write with read trigger reads region
// R16: read trigger reads back as zero
// R17: write with write trigger writes region
// R18: write trigger reads back as zero
// R19: software never sets both triggers together
// R20: base field holds address bits 6..30
// R21: index and select pick the region
// R22: region write stores, region read reloads
`timescale 1ns/1ps

module region_attr_access
  import region_attr_pkg::*;
#(
  parameter bit USE_LIMIT   = 1'b0,  // 0 mask variant, 1 limit variant
  parameter bit HAS_DCACHE  = 1'b1
) (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        ctl_wr_i,
  input  wire logic [4:0]  ctl_num_i,
  input  wire logic [31:0] ctl_wdata_i,
  output logic      [31:0] base_rdata_o,
  output logic      [31:0] attr_rdata_o,
  input  wire logic        prot_en_i,
  input  wire check_req_t  check_i,
  output check_rsp_t       check_o
);

  localparam int unsigned SIZE_W = USE_LIMIT ? LIMIT_W : BASE_W;  // see R7

  typedef struct packed {
    logic [BASE_W-1:0]  base;
    logic [IDX_W-1:0]   idx;
    logic               dsel;
    logic [LIMIT_W-1:0] size;
    logic               cache;
    logic [ACCESS_PERMISSION_CODE_W-1:0]  access_permission_code;
    acc_kind_t          pend;
    check_rsp_t         rsp;
    logic [31:0]        base_rd;
    logic [31:0]        attr_rd;
  } state_t;

  state_t        s_q;
  state_t        s_d;
  region_entry_t table_i_q [NUM_REGIONS];
  region_entry_t table_d_q [NUM_REGIONS];

  // size field as stored: mask variant keeps only BASE_W bits
  function automatic logic [LIMIT_W-1:0] clip_size(input logic [LIMIT_W-1:0] v);
    logic [LIMIT_W-1:0] r;
    r = v;
    if (!USE_LIMIT) begin
      r[LIMIT_W-1] = 1'b0;  // see R4
    end
    return r;
  endfunction : clip_size

  // read image of the attribute register; triggers always read as zero
  function automatic logic [31:0] attr_image(input logic [LIMIT_W-1:0] sz,
                                             input logic c,
                                             input logic [ACCESS_PERMISSION_CODE_W-1:0] p,
                                             input logic d);
    logic [31:0] r;
    r = 32'h0000_0000;                                  // see R16 R18
    r[31:SIZE_LSB] = clip_size(sz);                      // see R1 R2 R6
    r[CACHE_BIT] = d & c;                                // see R9
    r[ACCESS_PERMISSION_CODE_LSB +: ACCESS_PERMISSION_CODE_W] = p;
    return r;
  endfunction : attr_image

  // permission decode shared by fetch and data checks
  function automatic logic access_permission_code_ok(input logic [ACCESS_PERMISSION_CODE_W-1:0] p,
                                   input logic d,
                                   input logic usr,
                                   input logic st);
    logic ok;
    ok = 1'b0;
    if (!d) begin                                        // see R12
      case (p)
        ACCESS_PERMISSION_CODE_I_SUP_X: ok = !usr;
        ACCESS_PERMISSION_CODE_I_ALL_X: ok = 1'b1;
        default:      ok = 1'b0;
      endcase
    end else begin                                       // see R13
      case (p)
        ACCESS_PERMISSION_CODE_D_SUP_R:        ok = !usr && !st;
        ACCESS_PERMISSION_CODE_D_ALL_R:        ok = !st;
        ACCESS_PERMISSION_CODE_D_SUP_RW:       ok = !usr;
        ACCESS_PERMISSION_CODE_D_SUP_RW_USR_R: ok = !usr || !st;
        ACCESS_PERMISSION_CODE_D_ALL_RW:       ok = 1'b1;
        default:             ok = 1'b0;               // unlisted codes deny
      endcase
    end
    return ok;
  endfunction : access_permission_code_ok

  // region match, mask or limit form on address bits 6..30
  function automatic logic region_hit(input region_entry_t e,
                                      input logic [31:0] a);
    logic [LIMIT_W-1:0] blk;
    logic               h;
    blk = {1'b0, a[30:BASE_LSB]};                        // see R20
    if (USE_LIMIT) begin
      h = (blk >= {1'b0, e.base}) && (blk < e.size);      // see R5
    end else begin
      h = ((blk[BASE_W-1:0] ^ e.base) & e.size[BASE_W-1:0]) == '0;  // see R3
    end
    return h;
  endfunction : region_hit

  // region selected by the current index and select bit
  region_entry_t sel_e;
  always_comb begin
    sel_e = s_q.dsel ? table_d_q[s_q.idx] : table_i_q[s_q.idx];  // see R21
  end

  // lowest-numbered matching region wins the check
  logic        hit_any;
  logic        hit_ok;
  logic        hit_c;
  always_comb begin
    region_entry_t e;
    e       = '0;
    hit_any = 1'b0;
    hit_ok  = 1'b0;
    hit_c   = 1'b0;
    for (int i = NUM_REGIONS - 1; i >= 0; i--) begin
      e = check_i.data ? table_d_q[i] : table_i_q[i];
      if (region_hit(e, check_i.addr)) begin
        hit_any = 1'b1;
        hit_ok  = access_permission_code_ok(e.access_permission_code, check_i.data, check_i.user, check_i.store);
        hit_c   = e.cache;
      end
    end
  end

  // next state: register writes, trigger decode, region read reload, check
  always_comb begin
    s_d         = s_q;
    s_d.pend    = ACC_NONE;
    if (ctl_wr_i && ctl_num_i == CTL_BASE_NUM) begin
      s_d.base = ctl_wdata_i[30:BASE_LSB];
      s_d.idx  = ctl_wdata_i[IDX_LSB +: IDX_W];
      s_d.dsel = ctl_wdata_i[DSEL_BIT];
    end
    if (ctl_wr_i && ctl_num_i == CTL_ATTR_NUM) begin
      s_d.size  = clip_size(LIMIT_W'(ctl_wdata_i[31:SIZE_LSB]));
      s_d.cache = ctl_wdata_i[CACHE_BIT];
      s_d.access_permission_code  = ctl_wdata_i[ACCESS_PERMISSION_CODE_LSB +: ACCESS_PERMISSION_CODE_W];
      // read wins if both are set; the pairing is left undefined
      if (ctl_wdata_i[RD_BIT]) begin
        s_d.pend = ACC_READ;                             // see R15 R19
      end else if (ctl_wdata_i[WR_BIT]) begin
        s_d.pend = ACC_WRITE;                            // see R17
      end
    end
    // region read completes one cycle after the trigger
    if (s_q.pend == ACC_READ) begin                      // see R22
      s_d.base  = sel_e.base;
      s_d.size  = sel_e.size;
      s_d.cache = sel_e.cache;
      s_d.access_permission_code  = sel_e.access_permission_code;
    end
    s_d.base_rd = {1'b0, s_d.base, s_d.idx, s_d.dsel};
    s_d.attr_rd = attr_image(s_d.size, s_d.cache, s_d.access_permission_code, s_d.dsel);
    // check verdict; bit 31 bypass and io instructions force uncached
    s_d.rsp.valid     = check_i.valid;
    s_d.rsp.hit       = check_i.valid && hit_any;
    s_d.rsp.allow     = check_i.valid && (!prot_en_i || (hit_any && hit_ok));
    s_d.rsp.cacheable = check_i.valid && check_i.data && HAS_DCACHE      // see R10
                        && !check_i.io_insn && !check_i.addr[31]        // see R11
                        && (!prot_en_i || (hit_any && hit_c));          // see R8
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // region table: written one cycle after a write trigger
  always_ff @(posedge ref_clk_i) begin
    if (s_q.pend == ACC_WRITE) begin                     // see R22
      if (s_q.dsel) begin
        table_d_q[s_q.idx] <= '{base: s_q.base, size: s_q.size,
                                cache: s_q.cache, access_permission_code: s_q.access_permission_code};
      end else begin
        table_i_q[s_q.idx] <= '{base: s_q.base, size: s_q.size,
                                cache: 1'b0, access_permission_code: s_q.access_permission_code};  // see R9
      end
    end
  end

  assign base_rdata_o = s_q.base_rd;
  assign attr_rdata_o = s_q.attr_rd;
  assign check_o      = s_q.rsp;

  a_trig_read_zero: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    attr_rdata_o[RD_BIT +: 1] == 1'b0 && attr_rdata_o[WR_BIT] == 1'b0)  // see R16
    else $error("trigger bits read nonzero");
  a_mask_top_zero: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !USE_LIMIT |-> attr_rdata_o[31] == 1'b0)  // see R4
    else $error("mask variant bit 31 nonzero");
  a_icache_zero: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !base_rdata_o[DSEL_BIT] |-> !attr_rdata_o[CACHE_BIT])  // see R9
    else $error("instruction region reads cacheable");
  a_attr_follows: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    ctl_wr_i && ctl_num_i == CTL_ATTR_NUM && !ctl_wdata_i[RD_BIT]
    |=> attr_rdata_o[ACCESS_PERMISSION_CODE_LSB +: ACCESS_PERMISSION_CODE_W] == $past(ctl_wdata_i[ACCESS_PERMISSION_CODE_LSB +: ACCESS_PERMISSION_CODE_W]))  // see R2
    else $error("attribute write not stored");
  a_read_reload: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    ctl_wr_i && ctl_num_i == CTL_ATTR_NUM && ctl_wdata_i[RD_BIT]
    |=> s_q.pend == ACC_READ ##1 s_q.access_permission_code == $past(sel_e.access_permission_code))  // see R15
    else $error("region read did not reload");
  a_write_trig: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    ctl_wr_i && ctl_num_i == CTL_ATTR_NUM && ctl_wdata_i[WR_BIT] && !ctl_wdata_i[RD_BIT]
    |=> s_q.pend == ACC_WRITE ##1 sel_e.access_permission_code == $past(s_q.access_permission_code, 1))  // see R17
    else $error("region write not stored");
  a_io_uncached: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    check_i.valid && (check_i.io_insn || check_i.addr[31]) |=> !check_o.cacheable)  // see R10
    else $error("uncached access marked cacheable");
  a_fetch_nocache: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    check_i.valid && !check_i.data |=> !check_o.cacheable)  // see R8
    else $error("fetch marked cacheable");

  // region read reload: every field comes back, not only the permission code;
  // a base write in the reload cycle loses to the reload, so it is not excluded
  a_reload_base: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)  // see R22
    s_q.pend == ACC_READ |=> s_q.base == $past(sel_e.base))
    else $error("region read did not reload base");

  a_reload_size: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)  // see R22
    s_q.pend == ACC_READ |=> s_q.size == $past(sel_e.size))
    else $error("region read did not reload size");

  a_reload_cache: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)  // see R22
    s_q.pend == ACC_READ |=> s_q.cache == $past(sel_e.cache))
    else $error("region read did not reload cache flag");

  // region write store: the entry picked by index and select takes the fields;
  // a base write in the store cycle moves the selection, so it is left out
  a_store_base: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)  // see R22
    s_q.pend == ACC_WRITE && !(ctl_wr_i && ctl_num_i == CTL_BASE_NUM)
    |=> sel_e.base == $past(s_q.base))
    else $error("region write did not store base");

  a_store_size: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)  // see R22
    s_q.pend == ACC_WRITE && !(ctl_wr_i && ctl_num_i == CTL_BASE_NUM)
    |=> sel_e.size == $past(s_q.size))
    else $error("region write did not store size");

  // fetch entries never hold a cacheable flag, whatever software wrote
  a_icache_store: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)  // see R9
    s_q.pend == ACC_WRITE && !s_q.dsel && !(ctl_wr_i && ctl_num_i == CTL_BASE_NUM)
    |=> !sel_e.cache)
    else $error("instruction entry stored cacheable");

  // triggers act once: a pending operation clears unless a new trigger arrives
  a_trig_one_shot: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)  // see R15
    s_q.pend != ACC_NONE && !(ctl_wr_i && ctl_num_i == CTL_ATTR_NUM)
    |=> s_q.pend == ACC_NONE)
    else $error("region operation repeated");

  // base register image follows a plain write; bit 31 is never a field
  a_base_follows: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)  // see R20
    ctl_wr_i && ctl_num_i == CTL_BASE_NUM && s_q.pend != ACC_READ
    |=> base_rdata_o[30:BASE_LSB] == $past(ctl_wdata_i[30:BASE_LSB]))
    else $error("base write not stored");

  a_base_top_zero: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)  // see R20
    base_rdata_o[31] == 1'b0)
    else $error("base image bit 31 nonzero");

  // size field: the mask keeps the base width, the limit reaches bit 31
  a_mask_stored: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)  // see R1
    !USE_LIMIT |-> s_q.size[LIMIT_W-1] == 1'b0)
    else $error("mask wider than base field");

  a_size_follows: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)  // see R3
    ctl_wr_i && ctl_num_i == CTL_ATTR_NUM && s_q.pend != ACC_READ
    |=> attr_rdata_o[30:SIZE_LSB] == $past(ctl_wdata_i[30:SIZE_LSB]))
    else $error("size write not stored");

  // only reachable in the limit variant; the mask variant keeps it vacuous
  a_limit_top: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)  // see R6
    USE_LIMIT && ctl_wr_i && ctl_num_i == CTL_ATTR_NUM && s_q.pend != ACC_READ
    |=> attr_rdata_o[31] == $past(ctl_wdata_i[31]))
    else $error("limit bit 31 not stored");

  // data regions keep the cacheable flag as written
  a_cache_follows: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)  // see R8
    ctl_wr_i && ctl_num_i == CTL_ATTR_NUM && s_q.dsel && s_q.pend != ACC_READ
    |=> attr_rdata_o[CACHE_BIT] == $past(ctl_wdata_i[CACHE_BIT]))
    else $error("data cacheable flag not stored");

  // every check gets exactly one verdict, one cycle later
  a_check_valid: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)  // see R12
    check_i.valid |=> check_o.valid)
    else $error("check verdict missing");

  a_check_idle: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)  // see R12
    !check_i.valid |=> check_o == '0)
    else $error("verdict without a check");

  // protection off lets everything through; on, a miss is denied and uncached
  a_prot_off_allow: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)  // see R13
    check_i.valid && !prot_en_i |=> check_o.allow)
    else $error("access denied with protection off");

  a_miss_denies: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)  // see R13
    check_i.valid && prot_en_i && !hit_any |=> !check_o.allow && !check_o.cacheable)
    else $error("region miss allowed");

  // without a data cache nothing may be reported cacheable
  a_no_dcache: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)  // see R10
    !HAS_DCACHE |-> !check_o.cacheable)
    else $error("cacheable without data cache");

endmodule : region_attr_access

// ===== bench/mpu_region_attribute_access_test.sv
// self-checking bench for the region attribute and base control registers
// assumes the mask variant with a data cache and drives every port directly
`timescale 1ns/1ps

module mpu_region_attribute_access_test;
  import region_attr_pkg::*;

  logic        ref_clk_i;
  logic        reset_n_i;
  logic        ctl_wr_i;
  logic [4:0]  ctl_num_i;
  logic [31:0] ctl_wdata_i;
  logic [31:0] base_rdata_o;
  logic [31:0] attr_rdata_o;
  logic        prot_en_i;
  check_req_t  check_i;
  check_rsp_t  check_o;
  int          mismatches;
  int          n_checks;
  logic [31:0] w;
  logic [24:0] b;
  logic [24:0] m;

  region_attr_access uut (
    .ref_clk_i    (ref_clk_i),
    .reset_n_i    (reset_n_i),
    .ctl_wr_i     (ctl_wr_i),
    .ctl_num_i    (ctl_num_i),
    .ctl_wdata_i  (ctl_wdata_i),
    .base_rdata_o (base_rdata_o),
    .attr_rdata_o (attr_rdata_o),
    .prot_en_i    (prot_en_i),
    .check_i      (check_i),
    .check_o      (check_o)
  );

  // 40 MHz processor clock
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  // one comparison, counted; x never matches
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  // expected attribute image: bit 31 and triggers read zero, cache zero on fetch regions
  function automatic logic [31:0] attr_img(input logic [31:0] v, input logic d);
    return {1'b0, v[30:6], v[5] & d, v[4:2], 2'b00};
  endfunction : attr_img

  // listed codes only; unlisted codes deny by the designer's choice
  function automatic logic access_permission_code_ok(input logic d, input logic [2:0] p, input logic u,
                                   input logic s);
    if (!d) return u ? (p == 3'h2) : (p inside {3'h1, 3'h2});
    case ({u, s})
      2'b00:   return p inside {3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
      2'b10:   return p inside {3'h2, 3'h5, 3'h6};
      2'b01:   return p inside {3'h4, 3'h5, 3'h6};
      default: return p == 3'h6;
    endcase
  endfunction : access_permission_code_ok

  // one control-register write; strobe held for exactly the taking edge
  task automatic ctl_write(input logic [4:0] num, input logic [31:0] data);
    @(posedge ref_clk_i);
    ctl_wr_i    <= 1'b1;
    ctl_num_i   <= num;
    ctl_wdata_i <= data;
    @(posedge ref_clk_i);
    ctl_wr_i    <= 1'b0;
    #1;
  endtask : ctl_write

  // select a region, then store it with the write trigger
  task automatic region_wr(input logic d, input logic [4:0] i, input logic [24:0] rb,
                           input logic [24:0] rm, input logic c, input logic [2:0] p);
    ctl_write(CTL_BASE_NUM, {1'b0, rb, i, d});
    ctl_write(CTL_ATTR_NUM, {1'b0, rm, c, p, 2'b01});
    cmp(attr_rdata_o & 32'h3, 32'h0);
    repeat (2) @(posedge ref_clk_i);
  endtask : region_wr

  // one access check; the verdict stands a single cycle after it is taken
  task automatic chk(input logic d, input logic u, input logic s, input logic io,
                     input logic [31:0] a, input logic [3:0] exp, input logic [3:0] msk);
    @(posedge ref_clk_i);
    check_i <= check_req_t'({1'b1, d, u, s, io, a});
    @(posedge ref_clk_i);
    check_i <= '0;
    #1;
    cmp({28'h0, check_o & msk}, {28'h0, exp & msk});
  endtask : chk

  // watchdog sized well above the roughly 700 cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    mismatches++;
    test_done();
  end

  initial begin
    logic ok;
    reset_n_i   = 1'b0;
    ctl_wr_i    = 1'b0;
    ctl_num_i   = 5'h00;
    ctl_wdata_i = 32'h0;
    prot_en_i   = 1'b0;
    check_i     = '0;
    void'($urandom(32'h8F50));
    repeat (5) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    #1;
    cmp(base_rdata_o, BASE_RESET);
    cmp(attr_rdata_o, ATTR_RESET);
    // random field writes, all-ones corner first; bit 31 and triggers stay zero
    for (int k = 0; k < 20; k++) begin
      w = (k == 0) ? 32'hFFFF_FFFF : $urandom;
      ctl_write(CTL_BASE_NUM, w);
      cmp(base_rdata_o, w & 32'h7FFF_FFFF);
      w = (k == 0) ? 32'hFFFF_FFFC : ($urandom & 32'hFFFF_FFFC);
      if (!base_rdata_o[0]) w[5] = 1'b0;
      ctl_write(CTL_ATTR_NUM, w);
      cmp(attr_rdata_o, attr_img(w, base_rdata_o[0]));
    end
    ctl_write(5'h0D, 32'h0);
    cmp(attr_rdata_o, attr_img(w, base_rdata_o[0]));
    $display("test register images done");
    // store random entries, then reload them through the read trigger
    for (int k = 0; k < 8; k++) begin
      w = $urandom;
      b = $urandom;
      m = 25'h1FF_FFFF << ($urandom % 26);
      if (!w[0]) w[9:7] = w[9:7] % 3'h3;
      else if (w[8:7] == 2'b11) w[8:7] = 2'b10;
      w[6] = w[6] & w[0];
      region_wr(w[0], w[5:1], b, m, w[6], w[9:7]);
      ctl_write(CTL_BASE_NUM, {26'h0, w[5:1], w[0]});
      ctl_write(CTL_ATTR_NUM, 32'h0000_0002);
      repeat (3) @(posedge ref_clk_i);
      #1;
      cmp(base_rdata_o, {1'b0, b, w[5:1], w[0]});
      cmp(attr_rdata_o, attr_img({1'b0, m, w[6], w[9:7], 2'b00}, w[0]));
    end
    $display("test region round trip done");
    // park every other region far away as 64-byte no-access entries
    for (int d = 0; d < 2; d++) begin
      for (int i = 1; i < 32; i++) begin
        region_wr(d[0], i[4:0], 25'h100_0000, 25'h1FF_FFFF, 1'b0, 3'h0);
      end
    end
    prot_en_i <= 1'b1;
    // every listed code on both kinds over a 1 KB region at zero
    for (int d = 0; d < 2; d++) begin
      for (int p = 0; p < 8; p++) begin
        if (p == 3 || p == 7 || (d == 0 && p > 2)) continue;
        region_wr(d[0], 5'h0, 25'h0, 25'h1FF_FFF0, p[0] & d[0], p[2:0]);
        for (int us = 0; us < 4; us++) begin
          ok = access_permission_code_ok(d[0], p[2:0], us[1], us[0] & d[0]);
          w  = $urandom & 32'h0000_03FC;
          chk(d[0], us[1], us[0] & d[0], 1'b0, w, {2'b11, ok, p[0] & d[0]},
              ok ? 4'hF : 4'hE);
        end
      end
    end
    chk(1'b1, 1'b0, 1'b0, 1'b0, 32'h0000_8000, 4'h8, 4'hF);
    region_wr(1'b1, 5'h0, 25'h0, 25'h1FF_FFF0, 1'b1, 3'h6);
    chk(1'b1, 1'b0, 1'b0, 1'b1, 32'h0000_0100, 4'h0, 4'h1);
    chk(1'b1, 1'b0, 1'b0, 1'b0, 32'h8000_0100, 4'h0, 4'h1);
    chk(1'b1, 1'b1, 1'b1, 1'b0, 32'h0000_0100, 4'hF, 4'hF);
    prot_en_i <= 1'b0;
    chk(1'b1, 1'b1, 1'b1, 1'b0, 32'h0000_8000, 4'hA, 4'hA);
    $display("test permission checks done");
    test_done();
  end

endmodule : mpu_region_attribute_access_test
